// ---- pin_state_map.vh ----
// Constants for the pin-state controller: register offsets, reset values, state codes, pin positions.
// Assumes a byte-wide register port and an 8-pin-per-port numbering with port 0 at the bottom.
// Functional notes
// - Analog-input port pins stay high impedance in every state.
// - Multiplexed port pins are weakly pulled high until their function select is written; the code gives port 5 bit 4 a medium pull-up instead.
// - Fetch-flag / slave-select pin is weakly pulled low during and after reset.
// - Bus-hold-acknowledge pin has medium pull-up in reset; later follows function select.
// - Address/data pins weakly pulled high in reset, high impedance after release.
// - Address/data pins in idle/powerdown: high impedance if access low, else open-drain.
// - Reset pin driven strongly low in reset, medium pull-up otherwise.
// - Clock output active and strongly driven in reset; some variants float it instead.
// - In powerdown clock output is strong low if its select bit is 1, else programmed.
// - Select bit 0 keeps programmed value; select 1 gives direction and peripheral control.
// - Select 1 and hold-ack high: latch-enable, fetch pins low, byte-high-enable pin high.
// - Select 1 and hold-ack low: port 5 bus control pins float.
// - In powerdown oscillator output is the inverse of oscillator input.
// - Reset and post-reset states hold only until the port select register is written.
// - In idle transmit pin is high for control 01, carries data for control 10.
// - Receive pin always weakly pulled high; transmit high in reset and powerdown.
// - Reset edge or internal reset pulls reset pin low 16 state times, restart at 2080H.
`ifndef PIN_STATE_MAP_VH
`define PIN_STATE_MAP_VH

`define ADDR_W 5
`define OFS_P1_FSEL 5'h00
`define OFS_P1_DIR 5'h01
`define OFS_P1_DATA 5'h02
`define OFS_P2_FSEL 5'h04
`define OFS_P2_DIR 5'h05
`define OFS_P2_DATA 5'h06
`define OFS_P5_FSEL 5'h08
`define OFS_P5_DIR 5'h09
`define OFS_P5_DATA 5'h0A
`define OFS_P6_FSEL 5'h0C
`define OFS_P6_DIR 5'h0D
`define OFS_P6_DATA 5'h0E
`define OFS_P3_DATA 5'h10
`define OFS_P4_DATA 5'h11
`define OFS_MSG_CTL 5'h12
`define OFS_STATUS 5'h13

`define RST_P1_FSEL 8'h00
`define RST_P2_FSEL 8'h80
`define RST_P5_FSEL 8'h80
`define RST_P6_FSEL 8'h00
`define RST_P2_DIR 8'h7F
`define RST_DIR 8'hFF
`define RST_P2_DATA 8'h7F
`define RST_DATA 8'hFF
`define RST_MSG_CTL 2'h0

`define MSG_CTL_HIGH 2'h1
`define MSG_CTL_DATA 2'h2

`define RST_STATE_TIMES 16
`define RESTART_ADDR 16'h2080

`define ST_HIZ 3'h0
`define ST_WEAK_UP 3'h1
`define ST_WEAK_DOWN 3'h2
`define ST_MEDIUM_UP 3'h3
`define ST_DRIVE_LOW 3'h4
`define ST_DRIVE_HIGH 3'h5
`define ST_PUSH 3'h6
`define ST_ODIO 3'h7

`define PORT_ANALOG 0
`define PORT_1 1
`define PORT_2 2
`define PORT_ADL 3
`define PORT_ADH 4
`define PORT_5 5
`define PORT_6 6
`define BIT_CLOCK_OUTPUT 7
`define BIT_HOLD_ACK 6
`define BIT_FETCH_SEL 1
`define BIT_P5_MEDIUM 4
`define BIT_LATCH_EN 0
`define BIT_BYTE_HIGH 5
`define BIT_READY 6
`define BIT_BUSWIDTH 7

`endif

// ---- pin_state_encoder.v ----
// Turns one three-bit state code per pin into drive, float and pull enables.
// Assumes codes from pin_state_map.vh; purely combinational, the caller registers the outputs.
`timescale 1ns/1ns
`include "pin_state_map.vh"
module pin_state_encoder #(
   parameter N = 56
) (
   input wire [3*N-1:0] code_in,
   input wire [N-1:0] data_in,
   output reg [N-1:0] oe_n_out,
   output reg [N-1:0] do_out,
   output reg [N-1:0] wkup_out,
   output reg [N-1:0] wkdn_out,
   output reg [N-1:0] mdup_out
);
   integer i;
   always @*
   begin
      oe_n_out = {N{1'b1}};
      do_out = {N{1'b0}};
      wkup_out = {N{1'b0}};
      wkdn_out = {N{1'b0}};
      mdup_out = {N{1'b0}};
      for (i = 0; i < N; i = i + 1)
      begin
         case (code_in[3*i +: 3])
            `ST_WEAK_UP: wkup_out[i] = 1'b1;
            `ST_WEAK_DOWN: wkdn_out[i] = 1'b1;
            `ST_MEDIUM_UP: mdup_out[i] = 1'b1;
            `ST_DRIVE_LOW: oe_n_out[i] = 1'b0;
            `ST_DRIVE_HIGH:
            begin
               oe_n_out[i] = 1'b0;
               do_out[i] = 1'b1;
            end
            `ST_PUSH:
            begin
               oe_n_out[i] = 1'b0;
               do_out[i] = data_in[i];
            end
            `ST_ODIO: oe_n_out[i] = data_in[i];
            default: oe_n_out[i] = 1'b1;
         endcase
      end
   end
endmodule // pin_state_encoder

// ---- pin_state_ctrl.v ----
// Pin-state controller: decides each pin's drive in reset, after reset, run, idle and powerdown.
// Assumes pin-level inputs are asynchronous; mode, peripheral and message inputs are on mclk_in.
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/1ns
`include "pin_state_map.vh"
module pin_state_ctrl #(
   parameter STATE_TIME_CYCLES = 2,
   parameter CLOCK_OUTPUT_HIZ_IN_RESET = 0,
   parameter CNT_W = 8
) (
   input wire mclk_in,
   input wire rst_in,
   input wire ce_in,
   input wire [`ADDR_W-1:0] addr_in,
   input wire [7:0] wdata_in,
   input wire wr_in,
   input wire rd_in,
   output reg [7:0] rdata_out,
   input wire reset_pin_n_in,
   input wire internal_reset_in,
   input wire bus_hold_acknowledge_n_in,
   input wire external_access_n_in,
   input wire oscillator_input_in,
   input wire idle_in,
   input wire powerdown_in,
   input wire [55:0] periph_data_in,
   input wire msgbus_transmit_data_in,
   output reg [55:0] pin_oe_n_out,
   output reg [55:0] pin_do_out,
   output reg [55:0] pin_wkup_out,
   output reg [55:0] pin_wkdn_out,
   output reg [55:0] pin_mdup_out,
   output reg reset_pin_oe_n_out,
   output reg reset_pin_mdup_out,
   output reg oscillator_output_out,
   output reg msgbus_transmit_out,
   output reg msgbus_receive_wkup_out,
   output reg restart_out,
   output reg [15:0] restart_addr_out
);
   localparam integer PULSE_INT = `RST_STATE_TIMES * STATE_TIME_CYCLES;
   localparam [CNT_W-1:0] PULSE_CYCLES = PULSE_INT[CNT_W-1:0];

   reg [3:0] sync1_r;
   reg [3:0] sync2_r;
   reg rst_pin_prev_r;
   reg [CNT_W-1:0] pulse_cnt_r;
   reg dev_reset_r;
   reg clk_div_r;
   reg [7:0] p1_fsel_r, p1_dir_r, p1_data_r;
   reg [7:0] p2_fsel_r, p2_dir_r, p2_data_r;
   reg [7:0] p5_fsel_r, p5_dir_r, p5_data_r;
   reg [7:0] p6_fsel_r, p6_dir_r, p6_data_r;
   reg [7:0] p3_data_r, p4_data_r;
   reg [1:0] msg_ctl_r;
   reg [3:0] fsel_written_r;
   reg [167:0] code_nxt;
   reg [55:0] data_nxt;
   reg [7:0] rdata_nxt;
   wire [55:0] enc_oe_n;
   wire [55:0] enc_do;
   wire [55:0] enc_wkup;
   wire [55:0] enc_wkdn;
   wire [55:0] enc_mdup;
   wire rst_pin_n_s = sync2_r[0];
   wire hold_ack_n_s = sync2_r[1];
   wire ext_access_n_s = sync2_r[2];
   wire osc_in_s = sync2_r[3];
   wire low_power = idle_in | powerdown_in;
   wire [55:0] fsel_v = {p6_fsel_r, p5_fsel_r, 16'h0000, p2_fsel_r, p1_fsel_r, 8'h00};
   wire [55:0] dir_v = {p6_dir_r, p5_dir_r, 16'hFFFF, p2_dir_r, p1_dir_r, 8'hFF};
   wire [55:0] port_v = {p6_data_r, p5_data_r, p4_data_r, p3_data_r, p2_data_r, p1_data_r, 8'h00};

   // Maps a port number to its function-select written flag
   function written_flag;
      input integer port;
      input [3:0] flags;
      begin
         case (port)
            `PORT_1: written_flag = flags[0];
            `PORT_2: written_flag = flags[1];
            `PORT_5: written_flag = flags[2];
            `PORT_6: written_flag = flags[3];
            default: written_flag = 1'b1;
         endcase
      end
   endfunction

   // State during reset and until the select register is written
   function [2:0] default_code;
      input integer port;
      input integer bitn;
      begin
         if (port == `PORT_ANALOG)
            default_code = `ST_HIZ;
         else if ((port == `PORT_2 && bitn == `BIT_HOLD_ACK) || (port == `PORT_5 && bitn == `BIT_P5_MEDIUM))
            default_code = `ST_MEDIUM_UP;
         else if (port == `PORT_5 && bitn == `BIT_FETCH_SEL)
            default_code = `ST_WEAK_DOWN;
         else
            default_code = `ST_WEAK_UP;
      end
   endfunction

   // Per-pin state selection
   integer i;
   integer pt;
   integer bn;
   always @*
   begin
      code_nxt = {168{1'b0}};
      data_nxt = {56{1'b0}};
      pt = 0;
      bn = 0;
      for (i = 0; i < 56; i = i + 1)
      begin
         pt = i / 8;
         bn = i % 8;
         data_nxt[i] = port_v[i];
         if (pt == `PORT_ANALOG)
            code_nxt[3*i +: 3] = `ST_HIZ;
         else if (dev_reset_r)
         begin
            code_nxt[3*i +: 3] = default_code(pt, bn);
            if (pt == `PORT_2 && bn == `BIT_CLOCK_OUTPUT)
            begin
               data_nxt[i] = clk_div_r;
               code_nxt[3*i +: 3] = (CLOCK_OUTPUT_HIZ_IN_RESET != 0) ? `ST_HIZ : `ST_PUSH;
            end
         end
         else if (pt == `PORT_ADL || pt == `PORT_ADH)
            code_nxt[3*i +: 3] = (low_power && ext_access_n_s) ? `ST_ODIO : `ST_HIZ;
         else if (!written_flag(pt, fsel_written_r))
         begin
            code_nxt[3*i +: 3] = default_code(pt, bn);
            if (pt == `PORT_2 && bn == `BIT_CLOCK_OUTPUT)
            begin
               data_nxt[i] = clk_div_r;
               code_nxt[3*i +: 3] = `ST_PUSH;
            end
         end
         else if (!fsel_v[i])
            code_nxt[3*i +: 3] = dir_v[i] ? `ST_ODIO : `ST_PUSH;
         else if (pt == `PORT_2 && bn == `BIT_CLOCK_OUTPUT)
         begin
            data_nxt[i] = clk_div_r;
            code_nxt[3*i +: 3] = powerdown_in ? `ST_DRIVE_LOW : `ST_PUSH;
         end
         else if (low_power && pt == `PORT_5 && (bn == `BIT_LATCH_EN || bn == `BIT_FETCH_SEL))
            code_nxt[3*i +: 3] = hold_ack_n_s ? `ST_DRIVE_LOW : `ST_HIZ;
         else if (low_power && pt == `PORT_5 && bn == `BIT_BYTE_HIGH)
            code_nxt[3*i +: 3] = hold_ack_n_s ? `ST_DRIVE_HIGH : `ST_HIZ;
         else if (low_power && pt == `PORT_5 && (bn == `BIT_READY || bn == `BIT_BUSWIDTH))
            code_nxt[3*i +: 3] = `ST_HIZ;
         else
         begin
            data_nxt[i] = periph_data_in[i];
            code_nxt[3*i +: 3] = dir_v[i] ? `ST_ODIO : `ST_PUSH;
         end
      end
   end

   pin_state_encoder #(
      .N(56)
   ) pin_state_encoder_i (
      .code_in(code_nxt),
      .data_in(data_nxt),
      .oe_n_out(enc_oe_n),
      .do_out(enc_do),
      .wkup_out(enc_wkup),
      .wkdn_out(enc_wkdn),
      .mdup_out(enc_mdup)
   );

   // Register read mux
   always @*
   begin
      case (addr_in)
         `OFS_P1_FSEL: rdata_nxt = p1_fsel_r;
         `OFS_P1_DIR: rdata_nxt = p1_dir_r;
         `OFS_P1_DATA: rdata_nxt = p1_data_r;
         `OFS_P2_FSEL: rdata_nxt = p2_fsel_r;
         `OFS_P2_DIR: rdata_nxt = p2_dir_r;
         `OFS_P2_DATA: rdata_nxt = p2_data_r;
         `OFS_P5_FSEL: rdata_nxt = p5_fsel_r;
         `OFS_P5_DIR: rdata_nxt = p5_dir_r;
         `OFS_P5_DATA: rdata_nxt = p5_data_r;
         `OFS_P6_FSEL: rdata_nxt = p6_fsel_r;
         `OFS_P6_DIR: rdata_nxt = p6_dir_r;
         `OFS_P6_DATA: rdata_nxt = p6_data_r;
         `OFS_P3_DATA: rdata_nxt = p3_data_r;
         `OFS_P4_DATA: rdata_nxt = p4_data_r;
         `OFS_MSG_CTL: rdata_nxt = {6'h00, msg_ctl_r};
         `OFS_STATUS: rdata_nxt = {1'b0, powerdown_in, idle_in, dev_reset_r, fsel_written_r};
         default: rdata_nxt = 8'h00;
      endcase
   end

   // Synchronisers, reset pulse and clock divider
   always @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         sync1_r <= 4'hF;
         sync2_r <= 4'hF;
         rst_pin_prev_r <= 1'b1;
         pulse_cnt_r <= PULSE_CYCLES;
         dev_reset_r <= 1'b1;
         clk_div_r <= 1'b0;
         restart_out <= 1'b0;
         restart_addr_out <= `RESTART_ADDR;
      end
      else if (ce_in)
      begin
         sync1_r <= {oscillator_input_in, external_access_n_in, bus_hold_acknowledge_n_in, reset_pin_n_in};
         sync2_r <= sync1_r;
         rst_pin_prev_r <= rst_pin_n_s;
         clk_div_r <= ~clk_div_r;
         // Own pull-down is not taken as a fresh reset edge
         if (internal_reset_in || (rst_pin_prev_r && !rst_pin_n_s && pulse_cnt_r == {CNT_W{1'b0}}))
            pulse_cnt_r <= PULSE_CYCLES;
         else if (pulse_cnt_r != {CNT_W{1'b0}})
            pulse_cnt_r <= pulse_cnt_r - 1'b1;
         dev_reset_r <= (pulse_cnt_r != {CNT_W{1'b0}}) || !rst_pin_n_s || internal_reset_in;
         restart_out <= dev_reset_r && pulse_cnt_r == {CNT_W{1'b0}} && rst_pin_n_s && !internal_reset_in;
         restart_addr_out <= `RESTART_ADDR;
      end
   end

   // Configuration registers
   always @(posedge mclk_in)
   begin
      if (rst_in || (ce_in && dev_reset_r))
      begin
         p1_fsel_r <= `RST_P1_FSEL;
         p2_fsel_r <= `RST_P2_FSEL;
         p5_fsel_r <= `RST_P5_FSEL;
         p6_fsel_r <= `RST_P6_FSEL;
         p1_dir_r <= `RST_DIR;
         p2_dir_r <= `RST_P2_DIR;
         p5_dir_r <= `RST_DIR;
         p6_dir_r <= `RST_DIR;
         p1_data_r <= `RST_DATA;
         p2_data_r <= `RST_P2_DATA;
         p5_data_r <= `RST_DATA;
         p6_data_r <= `RST_DATA;
         p3_data_r <= `RST_DATA;
         p4_data_r <= `RST_DATA;
         msg_ctl_r <= `RST_MSG_CTL;
         fsel_written_r <= 4'h0;
      end
      else if (ce_in && wr_in)
      begin
         case (addr_in)
            `OFS_P1_FSEL:
            begin
               p1_fsel_r <= wdata_in;
               fsel_written_r[0] <= 1'b1;
            end
            `OFS_P2_FSEL:
            begin
               p2_fsel_r <= wdata_in;
               fsel_written_r[1] <= 1'b1;
            end
            `OFS_P5_FSEL:
            begin
               p5_fsel_r <= wdata_in;
               fsel_written_r[2] <= 1'b1;
            end
            `OFS_P6_FSEL:
            begin
               p6_fsel_r <= wdata_in;
               fsel_written_r[3] <= 1'b1;
            end
            `OFS_P1_DIR: p1_dir_r <= wdata_in;
            `OFS_P2_DIR: p2_dir_r <= wdata_in;
            `OFS_P5_DIR: p5_dir_r <= wdata_in;
            `OFS_P6_DIR: p6_dir_r <= wdata_in;
            `OFS_P1_DATA: p1_data_r <= wdata_in;
            `OFS_P2_DATA: p2_data_r <= wdata_in;
            `OFS_P5_DATA: p5_data_r <= wdata_in;
            `OFS_P6_DATA: p6_data_r <= wdata_in;
            `OFS_P3_DATA: p3_data_r <= wdata_in;
            `OFS_P4_DATA: p4_data_r <= wdata_in;
            `OFS_MSG_CTL: msg_ctl_r <= wdata_in[1:0];
            default: msg_ctl_r <= msg_ctl_r;
         endcase
      end
   end

   // Output registers
   always @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         rdata_out <= 8'h00;
         pin_oe_n_out <= {56{1'b1}};
         pin_do_out <= {56{1'b0}};
         pin_wkup_out <= {{48{1'b1}}, 8'h00};
         pin_wkdn_out <= {56{1'b0}};
         pin_mdup_out <= {56{1'b0}};
         reset_pin_oe_n_out <= 1'b0;
         reset_pin_mdup_out <= 1'b0;
         oscillator_output_out <= 1'b0;
         msgbus_transmit_out <= 1'b1;
         msgbus_receive_wkup_out <= 1'b1;
      end
      else if (ce_in)
      begin
         rdata_out <= rd_in ? rdata_nxt : 8'h00;
         pin_oe_n_out <= enc_oe_n;
         pin_do_out <= enc_do;
         pin_wkup_out <= enc_wkup;
         pin_wkdn_out <= enc_wkdn;
         pin_mdup_out <= enc_mdup;
         // Driving from the pulse only, so the sensed pin cannot hold its own reset
         reset_pin_oe_n_out <= (pulse_cnt_r == {CNT_W{1'b0}});
         reset_pin_mdup_out <= ~dev_reset_r;
         oscillator_output_out <= ~osc_in_s;
         if (!dev_reset_r && !powerdown_in && msg_ctl_r == `MSG_CTL_DATA)
            msgbus_transmit_out <= msgbus_transmit_data_in;
         else
            msgbus_transmit_out <= 1'b1;
         msgbus_receive_wkup_out <= 1'b1;
      end
   end
endmodule // pin_state_ctrl

// ---- pin_state_ctrl_monitor.sv ----
// Checker for pin_state_ctrl: pin states in reset and powerdown, and the reset pulse.
// Assumes one clock and the synchronous reset rst_in; bound to every pin_state_ctrl.
`timescale 1ns/1ns
module pin_state_ctrl_monitor #(
   parameter STATE_TIME_CYCLES = 2
) (
   input wire mclk_in,
   input wire rst_in,
   input wire internal_reset_in,
   input wire oscillator_input_in,
   input wire powerdown_in,
   input wire external_access_n_in,
   input wire [55:0] pin_oe_n_out,
   input wire [55:0] pin_wkup_out,
   input wire [55:0] pin_wkdn_out,
   input wire [55:0] pin_mdup_out,
   input wire reset_pin_oe_n_out,
   input wire oscillator_output_out,
   input wire msgbus_transmit_out,
   input wire msgbus_receive_wkup_out,
   input wire restart_out,
   input wire [15:0] restart_addr_out
);
   localparam int PLO = 16 * STATE_TIME_CYCLES;
   localparam int PHI = PLO + 40;
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (rst_in);
   analog_float_a: assert property
      (pin_oe_n_out[7:0] == 8'hFF && (pin_wkup_out[7:0] | pin_wkdn_out[7:0] | pin_mdup_out[7:0]) == 8'h00)
      else $error("analog pins not floating");
   ad_reset_pull_a: assert property (disable iff (1'b0) rst_in[*3] |-> &pin_wkup_out[39:24])
      else $error("address/data pins not pulled up in reset");
   rst_pin_drive_a: assert property (disable iff (1'b0) rst_in[*3] |-> !reset_pin_oe_n_out)
      else $error("reset pin not driven low in reset");
   rx_pull_a: assert property (!rst_in ##1 !rst_in |-> msgbus_receive_wkup_out)
      else $error("receive pin pull-up off");
   tx_pd_high_a: assert property (powerdown_in[*3] |-> msgbus_transmit_out)
      else $error("transmit pin not high in powerdown");
   osc_inverse_a: assert property
      (($stable(oscillator_input_in) && powerdown_in)[*5] |-> oscillator_output_out == !oscillator_input_in)
      else $error("oscillator output not inverted");
   ad_pd_float_a: assert property
      ((powerdown_in && !external_access_n_in)[*5] |-> &pin_oe_n_out[39:24])
      else $error("address/data pins driven with access low");
   reset_restart_a: assert property
      ($rose(internal_reset_in) |-> ##[PLO:PHI] (restart_out && restart_addr_out == 16'h2080))
      else $error("no restart after internal reset");
   reset_pulse_a: assert property ($rose(internal_reset_in) |-> ##2 (!reset_pin_oe_n_out)[*8])
      else $error("reset pin pulse too short");
endmodule // pin_state_ctrl_monitor

bind pin_state_ctrl pin_state_ctrl_monitor #(.STATE_TIME_CYCLES(STATE_TIME_CYCLES)) pin_state_ctrl_monitor_i (
   .mclk_in, .rst_in, .internal_reset_in, .oscillator_input_in, .powerdown_in, .external_access_n_in,
   .pin_oe_n_out, .pin_wkup_out, .pin_wkdn_out, .pin_mdup_out, .reset_pin_oe_n_out, .oscillator_output_out,
   .msgbus_transmit_out, .msgbus_receive_wkup_out, .restart_out, .restart_addr_out
);

// ---- board_model.sv ----
// Board model: open-drain reset wire, hold-acknowledge and access strap levels.
// Assumes the bench commands hold and strap; no other party drives these pins.
`timescale 1ns/1ns
module board_model (
   input wire reset_drive_n_in,
   input wire hold_in,
   input wire strap_in,
   output wire reset_level_out,
   output wire hold_ack_n_out,
   output wire access_n_out
);
   // Released reset wire rises through its pull-up
   assign reset_level_out = reset_drive_n_in;
   // Granted hold shows as a low acknowledge
   assign hold_ack_n_out = !hold_in;
   // Strap held at a firm level, never floating
   assign access_n_out = strap_in;
endmodule // board_model

// ---- pin_state_ctrl_tb.sv ----
// Testbench for pin_state_ctrl: register tasks and pin-state scenarios.
// Assumes board_model on reset, hold-acknowledge and strap pins; one 100 MHz clock.
`timescale 1ns/1ns
`include "pin_state_map.vh"
module pin_state_ctrl_tb;
   logic mclk_in = 0, rst_in = 1, ce_in = 1, wr_in = 0, rd_in = 0, internal_reset_in = 0, hold = 0, strap = 0;
   logic idle_in = 0, powerdown_in = 0, oscillator_input_in = 0, msgbus_transmit_data_in = 1;
   logic [4:0] addr_in = 5'h00;
   logic [7:0] wdata_in = 8'h00;
   logic [55:0] periph_data_in = 56'h0;
   wire [7:0] rdata_out;
   wire [55:0] pin_oe_n_out, pin_do_out, pin_wkup_out, pin_wkdn_out, pin_mdup_out;
   wire reset_pin_oe_n_out, reset_pin_mdup_out, oscillator_output_out, msgbus_transmit_out;
   wire msgbus_receive_wkup_out, restart_out, reset_level, hold_ack_n, access_n;
   wire [15:0] restart_addr_out;
   int err_total = 0, compares = 0, cycles = 0;
   logic [4:0] ra [17] = '{`OFS_P1_FSEL, `OFS_P1_DIR, `OFS_P1_DATA, `OFS_P2_FSEL, `OFS_P2_DIR, `OFS_P2_DATA,
      `OFS_P5_FSEL, `OFS_P5_DIR, `OFS_P5_DATA, `OFS_P6_FSEL, `OFS_P6_DIR, `OFS_P6_DATA, `OFS_P3_DATA,
      `OFS_P4_DATA, `OFS_MSG_CTL, `OFS_STATUS, 5'h1F};
   logic [7:0] rv [17] = '{`RST_P1_FSEL, `RST_DIR, `RST_DATA, `RST_P2_FSEL, `RST_P2_DIR, `RST_P2_DATA,
      `RST_P5_FSEL, `RST_DIR, `RST_DATA, `RST_P6_FSEL, `RST_DIR, `RST_DATA, `RST_DATA, `RST_DATA, 8'h00, 8'h00, 8'h00};
   pin_state_ctrl #(.STATE_TIME_CYCLES(1)) pin_state_ctrl_i (
      .mclk_in, .rst_in, .ce_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .reset_pin_n_in(reset_level),
      .internal_reset_in, .bus_hold_acknowledge_n_in(hold_ack_n), .external_access_n_in(access_n),
      .oscillator_input_in, .idle_in, .powerdown_in, .periph_data_in, .msgbus_transmit_data_in, .pin_oe_n_out,
      .pin_do_out, .pin_wkup_out, .pin_wkdn_out, .pin_mdup_out, .reset_pin_oe_n_out, .reset_pin_mdup_out,
      .oscillator_output_out, .msgbus_transmit_out, .msgbus_receive_wkup_out, .restart_out, .restart_addr_out
   );
   board_model board_model_i (.reset_drive_n_in(reset_pin_oe_n_out), .hold_in(hold), .strap_in(strap),
      .reset_level_out(reset_level), .hold_ack_n_out(hold_ack_n), .access_n_out(access_n));
   always #5 mclk_in = ~mclk_in;
   task automatic stop_test();
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   always @(posedge mclk_in)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         err_total++;
         stop_test();
      end
   end
   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         err_total++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge mclk_in);
      #1;
   endtask
   task automatic wr(logic [4:0] a, logic [7:0] d);
      @(posedge mclk_in);
      wr_in <= 1'b1;
      addr_in <= a;
      wdata_in <= d;
      @(posedge mclk_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(logic [4:0] a, logic [7:0] exp);
      @(posedge mclk_in);
      rd_in <= 1'b1;
      addr_in <= a;
      @(posedge mclk_in);
      rd_in <= 1'b0;
      #1;
      check("rdata", rdata_out, exp);
   endtask
   task automatic wait_restart();
      int n;
      n = 0;
      while (restart_out !== 1'b1 && n < 200)
      begin
         cyc(1);
         n++;
      end
      check("restart", restart_out, 1'b1);
      cyc(3);
   endtask
   initial
   begin
      repeat (8) @(posedge mclk_in);
      rst_in <= 1'b0;
      wait_restart();
      check("p0", {pin_oe_n_out[7:0], pin_wkup_out[7:0], pin_wkdn_out[7:0]}, 24'hFF0000);
      check("p1 pull", pin_wkup_out[15:8], 8'hFF);
      check("fetch pull", pin_wkdn_out[41], 1'b1);
      check("hold pull", pin_mdup_out[22], 1'b1);
      check("ad", {pin_oe_n_out[39:24], pin_wkup_out[39:24]}, 32'hFFFF0000);
      check("clk drive", pin_oe_n_out[23], 1'b0);
      check("rst pull", {reset_pin_oe_n_out, reset_pin_mdup_out}, 2'h3);
      check("tx", msgbus_transmit_out, 1'b1);
      for (int i = 0; i < 17; i++)
         rd(ra[i], rv[i]);
      $display("test reset done");
      @(posedge mclk_in);
      idle_in <= 1'b1;
      wr(`OFS_P1_DATA, 8'hA5);
      wr(`OFS_P1_DIR, 8'h00);
      wr(`OFS_P1_FSEL, 8'h00);
      cyc(3);
      check("p1 prog", {pin_oe_n_out[15:8], pin_do_out[15:8]}, 16'h00A5);
      rd(`OFS_STATUS, 8'h21);
      @(posedge mclk_in);
      periph_data_in[15:8] <= 8'h3C;
      wr(`OFS_P1_FSEL, 8'hFF);
      cyc(3);
      check("p1 periph", {pin_oe_n_out[15:8], pin_do_out[15:8]}, 16'h003C);
      wr(`OFS_P5_FSEL, 8'h23);
      cyc(3);
      check("p5", {pin_oe_n_out[45], pin_oe_n_out[41:40], pin_do_out[45], pin_do_out[41:40]}, 6'h04);
      @(posedge mclk_in);
      hold <= 1'b1;
      cyc(6);
      check("p5 float", {pin_oe_n_out[45], pin_oe_n_out[41:40]}, 3'h7);
      @(posedge mclk_in);
      msgbus_transmit_data_in <= 1'b0;
      wr(`OFS_MSG_CTL, 8'h02);
      cyc(3);
      check("tx data", msgbus_transmit_out, 1'b0);
      wr(`OFS_MSG_CTL, 8'h01);
      cyc(3);
      check("tx high", msgbus_transmit_out, 1'b1);
      $display("test idle done");
      @(posedge mclk_in);
      idle_in <= 1'b0;
      powerdown_in <= 1'b1;
      wr(`OFS_P2_FSEL, 8'h80);
      wr(`OFS_MSG_CTL, 8'h02);
      cyc(3);
      check("clk low", {pin_oe_n_out[23], pin_do_out[23]}, 2'h0);
      check("tx pd", msgbus_transmit_out, 1'b1);
      @(posedge mclk_in);
      oscillator_input_in <= 1'b1;
      cyc(6);
      check("osc", oscillator_output_out, 1'b0);
      @(posedge mclk_in);
      oscillator_input_in <= 1'b0;
      cyc(6);
      check("osc", oscillator_output_out, 1'b1);
      @(posedge mclk_in);
      strap <= 1'b1;
      wr(`OFS_P3_DATA, 8'h0F);
      cyc(6);
      check("ad odio", pin_oe_n_out[31:24], 8'h0F);
      $display("test powerdown done");
      @(posedge mclk_in);
      powerdown_in <= 1'b0;
      strap <= 1'b0;
      @(posedge mclk_in);
      internal_reset_in <= 1'b1;
      @(posedge mclk_in);
      internal_reset_in <= 1'b0;
      wait_restart();
      check("p1 pull", pin_wkup_out[15:8], 8'hFF);
      rd(`OFS_STATUS, 8'h00);
      $display("test internal reset done");
      stop_test();
   end
endmodule // pin_state_ctrl_tb
